// ---- verilog/adc_mode_and_trim_regs.v ----
// Purpose: Mode and trim register bank of a dual-channel converter,
//          reached through the four-wire serial control port.
// Assumes: csb, sclk and sdi are synchronous to clk and sclk is slower
//          than clk/2; stream_address_up comes from the port setup
//          register that lives outside this bank.
// Notes:   Frame is R/W bit (1 = read), 15 address bits, then data bytes
//          while csb stays low; sdi is taken on sclk rising, sdo moves
//          on sclk falling.
// What this block does
// - Bit 7 of the format register selects offset binary or two's complement.
// - Bits 4:3 choose no SYSREF offset, idle-low -400mV or idle-high +400mV.
// - Gate enable bit 2 low ignores SYSREF; high passes its edges to detection.
// - Divide register bits 4:3 select input clock divide by 1, 2, 4, 8.
// - Divide register resets with bits 7:5 at 100 and bits 2:0 at 000.
// - Amplitude trim codes shift termination by 10 ohm steps; 4 reserved.
// - Phase trim codes add 0.24 pF steps to positive or negative input.
// - Streaming addresses count up when the up bit is 1, else down.
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_trim_defs.vh"

module adc_mode_and_trim_regs (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       csb,
  input  wire       sclk,
  input  wire       sdi,
  output wire       sdo,
  output wire       sdo_oe,
  input  wire       stream_address_up,
  input  wire       sysref_in,
  output wire       sample_format_select,
  output reg        sysref_bias_low,
  output reg        sysref_bias_high,
  output wire       sysref_gate_enable,
  output wire       sysref_gated,
  output wire [1:0] sample_clock_divide,
  output reg  [3:0] clock_divide_ratio,
  output wire [2:0] chan_a_amplitude_trim,
  output wire [3:0] chan_a_phase_trim,
  output wire [1:0] amp_trim_steps,
  output wire       amp_trim_pos_up,
  output wire       amp_trim_reserved,
  output wire [2:0] phase_trim_steps,
  output wire       phase_trim_on_neg
);

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_HEADER = 3'b010;
  localparam [2:0] ST_DATA   = 3'b100;

  reg  [7:0]  output_format_sysref_config;
  reg  [7:0]  sample_clock_divide_config;
  reg  [7:0]  channel_a_input_balance_trim;
  reg  [2:0]  state;
  reg         sclk_q;
  reg  [4:0]  hdr_cnt;
  reg  [3:0]  data_cnt;
  reg  [15:0] hdr_shift;
  reg         rd_op;
  reg  [14:0] addr;
  reg  [7:0]  wr_shift;
  reg  [7:0]  rd_shift;
  wire        sclk_rise;
  wire        sclk_fall;
  wire [7:0]  next_wr_byte;
  wire [15:0] next_header;

  // Returns the byte held at a register address, zero where unmapped.
  function [7:0] read_mux;
    input [14:0] a;
    begin
      case (a)
        `OFS_OUTPUT_FORMAT_SYSREF: read_mux = output_format_sysref_config;
        `OFS_SAMPLE_CLOCK_DIVIDE:  read_mux = sample_clock_divide_config;
        `OFS_CHAN_A_BALANCE_TRIM:  read_mux = channel_a_input_balance_trim;
        default:                   read_mux = `RST_UNMAPPED_READ;
      endcase
    end
  endfunction

  // Edge detection on the serial clock, taken as a synchronous input.
  assign sclk_rise    = sclk & ~sclk_q;
  assign sclk_fall    = ~sclk & sclk_q;
  assign next_wr_byte = {wr_shift[6:0], sdi};
  assign next_header  = {hdr_shift[14:0], sdi};

  // Serial frame sequencer: header collection, then streamed data bytes.
  always @(posedge clk) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      sclk_q    <= 1'b0;
      hdr_cnt   <= 5'h0;
      data_cnt  <= 4'h0;
      hdr_shift <= 16'h0000;
      rd_op     <= 1'b0;
      addr      <= 15'h0000;
      wr_shift  <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (csb) begin
        state    <= ST_IDLE;
        hdr_cnt  <= 5'h0;
        data_cnt <= 4'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            state   <= ST_HEADER;
            hdr_cnt <= 5'h0;
            if (sclk_rise) begin
              hdr_shift <= next_header;
              hdr_cnt   <= 5'h1;
            end
          end
          ST_HEADER: begin
            if (sclk_rise) begin
              hdr_shift <= next_header;
              if (hdr_cnt == `HEADER_BITS - 5'h1) begin
                state    <= ST_DATA;
                rd_op    <= next_header[15];
                addr     <= next_header[14:0];
                data_cnt <= 4'h0;
              end else begin
                hdr_cnt <= hdr_cnt + 5'h1;
              end
            end
          end
          ST_DATA: begin
            if (sclk_rise) begin
              wr_shift <= next_wr_byte;
              if (data_cnt == `DATA_BITS - 4'h1) begin
                data_cnt <= 4'h0;
                if (stream_address_up) begin
                  addr <= addr + 15'h0001;
                end else begin
                  addr <= addr - 15'h0001;
                end
              end else begin
                data_cnt <= data_cnt + 4'h1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register writes land on the eighth data bit of each byte.
  always @(posedge clk) begin
    if (!rst_b) begin
      output_format_sysref_config  <= `RST_OUTPUT_FORMAT_SYSREF;
      sample_clock_divide_config   <= `RST_SAMPLE_CLOCK_DIVIDE;
      channel_a_input_balance_trim <= `RST_CHAN_A_BALANCE_TRIM;
    end else if (!csb && state == ST_DATA && sclk_rise && !rd_op &&
                 data_cnt == `DATA_BITS - 4'h1) begin
      case (addr)
        `OFS_OUTPUT_FORMAT_SYSREF:
          output_format_sysref_config <= next_wr_byte;
        `OFS_SAMPLE_CLOCK_DIVIDE:
          sample_clock_divide_config <= next_wr_byte;
        `OFS_CHAN_A_BALANCE_TRIM:
          channel_a_input_balance_trim <= next_wr_byte;
        default: begin
        end
      endcase
    end
  end

  // Read shifter: loads a byte on the first falling edge of each byte.
  always @(posedge clk) begin
    if (!rst_b) begin
      rd_shift <= 8'h00;
    end else if (!csb && state == ST_DATA && rd_op && sclk_fall) begin
      if (data_cnt == 4'h0) begin
        rd_shift <= read_mux(addr);
      end else begin
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  // Serial data out is driven only during the data phase of a read.
  assign sdo    = rd_shift[7];
  assign sdo_oe = ~csb & rd_op & (state == ST_DATA);

  // Field outputs follow the stored registers at once.
  assign sample_format_select =
    output_format_sysref_config[`FLD_SAMPLE_FORMAT];
  assign sysref_gate_enable =
    output_format_sysref_config[`FLD_SYSREF_GATE];
  assign sysref_gated = sysref_in & sysref_gate_enable;
  assign sample_clock_divide =
    sample_clock_divide_config[`FLD_CLOCK_DIVIDE_HI:`FLD_CLOCK_DIVIDE_LO];
  assign chan_a_amplitude_trim =
    channel_a_input_balance_trim[`FLD_AMP_TRIM_HI:`FLD_AMP_TRIM_LO];
  assign chan_a_phase_trim =
    channel_a_input_balance_trim[`FLD_PHASE_TRIM_HI:`FLD_PHASE_TRIM_LO];

  // SYSREF idle bias; the reserved code applies no bias.
  always @* begin
    sysref_bias_low  = 1'b0;
    sysref_bias_high = 1'b0;
    case (output_format_sysref_config[`FLD_SYSREF_IDLE_HI:
                                      `FLD_SYSREF_IDLE_LO])
      `SYSREF_IDLE_LOW:  sysref_bias_low  = 1'b1;
      `SYSREF_IDLE_HIGH: sysref_bias_high = 1'b1;
      default: begin
      end
    endcase
  end

  // Divide ratio as one-hot 1, 2, 4 or 8.
  always @* begin
    case (sample_clock_divide)
      2'h0:    clock_divide_ratio = 4'h1;
      2'h1:    clock_divide_ratio = 4'h2;
      2'h2:    clock_divide_ratio = 4'h4;
      default: clock_divide_ratio = 4'h8;
    endcase
  end

  // Trim code decoding for the channel A input network.
  trim_code_decode u_trim (
    .amp_code     (chan_a_amplitude_trim),
    .phase_code   (chan_a_phase_trim),
    .amp_steps    (amp_trim_steps),
    .amp_pos_up   (amp_trim_pos_up),
    .amp_reserved (amp_trim_reserved),
    .phase_steps  (phase_trim_steps),
    .phase_on_neg (phase_trim_on_neg)
  );

endmodule

`default_nettype wire

// ---- shared/adc_mode_trim_defs.vh ----
// Purpose: Offsets, field positions, reset values and port framing for the
//          converter mode and trim register bank.
// Assumes: Serial control port with a 16-bit header and 8-bit data words.
// Notes:   Definitions only.
`ifndef ADC_MODE_TRIM_DEFS_VH
`define ADC_MODE_TRIM_DEFS_VH

// Register offsets on the serial control port.
`define OFS_OUTPUT_FORMAT_SYSREF  15'h0012
`define OFS_SAMPLE_CLOCK_DIVIDE   15'h0013
`define OFS_CHAN_A_BALANCE_TRIM   15'h0014

// Reset values.
`define RST_OUTPUT_FORMAT_SYSREF  8'h81
`define RST_SAMPLE_CLOCK_DIVIDE   8'h80
`define RST_CHAN_A_BALANCE_TRIM   8'h00
`define RST_UNMAPPED_READ         8'h00

// Field positions in the output format and SYSREF register.
`define FLD_SAMPLE_FORMAT         7
`define FLD_SYSREF_IDLE_HI        4
`define FLD_SYSREF_IDLE_LO        3
`define FLD_SYSREF_GATE           2

// Field positions in the sample clock divide register.
`define FLD_CLOCK_DIVIDE_HI       4
`define FLD_CLOCK_DIVIDE_LO       3

// Field positions in the channel A balance trim register.
`define FLD_AMP_TRIM_HI           6
`define FLD_AMP_TRIM_LO           4
`define FLD_PHASE_TRIM_HI         3
`define FLD_PHASE_TRIM_LO         0

// SYSREF idle offset encodings.
`define SYSREF_IDLE_NONE          2'h0
`define SYSREF_IDLE_LOW           2'h1
`define SYSREF_IDLE_HIGH          2'h2

// Serial frame lengths in SCLK bits.
`define HEADER_BITS               5'h10
`define DATA_BITS                 4'h8

`endif

// ---- verilog/trim_code_decode.v ----
// Purpose: Turns the channel A amplitude and phase trim codes into
//          direction and step controls for the input network.
// Assumes: Codes come straight from the register bank.
// Notes:   Amplitude steps are 10 ohm, phase steps are 0.24 pF.
`timescale 1ns/1ps
`default_nettype none

module trim_code_decode (
  input  wire [2:0] amp_code,
  input  wire [3:0] phase_code,
  output reg  [1:0] amp_steps,
  output reg        amp_pos_up,
  output reg        amp_reserved,
  output reg  [2:0] phase_steps,
  output reg        phase_on_neg
);

  // Amplitude: 1..3 lower VIN+, 5..7 raise VIN+, 4 reserved, 0 no change.
  always @* begin
    amp_steps    = amp_code[1:0];
    amp_pos_up   = amp_code[2] & (amp_code[1:0] != 2'h0);
    amp_reserved = (amp_code == 3'h4);
    if (amp_reserved) begin
      amp_steps = 2'h0;
    end
  end

  // Phase: 1..7 load VIN+, 8..14 load VIN- with one step more than the
  // low bits. Code 15 holds at seven steps so the 3-bit count never wraps.
  always @* begin
    phase_on_neg = phase_code[3];
    if (phase_code == 4'hf) begin
      phase_steps = 3'h7;
    end else if (phase_code[3]) begin
      phase_steps = phase_code[2:0] + 3'h1;
    end else begin
      phase_steps = phase_code[2:0];
    end
  end

endmodule

`default_nettype wire

// ---- verification/spi_host_model.sv ----
// Purpose: Host on the serial control port of the mode and trim bank.
// Assumes: sclk idles low and moves only while csb is low.
// Notes:   A released sdo line reads as the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic clk,
  output var  logic csb,
  output var  logic sclk,
  output var  logic sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic last_sdo = 1'b0;
  wire  sdo_line = sdo_oe ? sdo : ~last_sdo;
  initial begin
    csb = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Remember what the bank last drove.
  always @(posedge clk) if (sdo_oe) last_sdo <= sdo;
  // Header then n bytes MSB first, lo clocks low and 4 high per bit.
  task automatic frame(input logic rd, input logic [14:0] a, input int n,
                       input logic [31:0] wd, input int lo,
                       output logic [31:0] q);
    logic [47:0] bits;
    bits = {rd, a, wd};
    q = 32'h0;
    @(posedge clk) csb <= 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      @(posedge clk) sclk <= 1'b0;
      sdi <= bits[47 - i];
      repeat (lo - 1) @(posedge clk);
      @(posedge clk) sclk <= 1'b1;
      if (i >= 16) q = {q[30:0], sdo_line};
      repeat (3) @(posedge clk);
    end
    @(posedge clk) sclk <= 1'b0;
    @(posedge clk) csb <= 1'b1;
    sdi <= ~sdi;
  endtask
endmodule
`default_nettype wire

// ---- verification/adc_mode_and_trim_regs_asserts.sv ----
// Purpose: Port checks for the mode and trim register bank.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Decoded outputs are tied to the register fields they follow.
`timescale 1ns/1ps
`default_nettype none
module adc_mode_trim_checker (
  input wire       clk,
  input wire       rst_b,
  input wire       csb,
  input wire       sdo_oe,
  input wire       sysref_in,
  input wire       sample_format_select,
  input wire       sysref_bias_low,
  input wire       sysref_bias_high,
  input wire       sysref_gate_enable,
  input wire       sysref_gated,
  input wire [1:0] sample_clock_divide,
  input wire [3:0] clock_divide_ratio,
  input wire [2:0] chan_a_amplitude_trim,
  input wire [3:0] chan_a_phase_trim,
  input wire [1:0] amp_trim_steps,
  input wire       amp_trim_pos_up,
  input wire       amp_trim_reserved,
  input wire [2:0] phase_trim_steps,
  input wire       phase_trim_on_neg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Field decodes and reset state.
  a_reset_state: assert property (
    $rose(rst_b) |-> sample_format_select && !sysref_gate_enable &&
    clock_divide_ratio == 4'h1 && chan_a_phase_trim == 4'h0)
    else $error("bad state after reset");
  a_bias_exclusive: assert property (
    !(sysref_bias_low && sysref_bias_high)) else $error("bias clash");
  a_gate_pass: assert property (
    sysref_gated == (sysref_in && sysref_gate_enable))
    else $error("gated SYSREF wrong");
  a_divide_ratio: assert property (
    clock_divide_ratio == 4'h1 << sample_clock_divide)
    else $error("divide ratio wrong");
  a_amp_decode: assert property (
    amp_trim_steps == chan_a_amplitude_trim[1:0] &&
    amp_trim_reserved == (chan_a_amplitude_trim == 3'h4) &&
    amp_trim_pos_up == (chan_a_amplitude_trim > 3'h4))
    else $error("amplitude decode wrong");
  a_phase_side: assert property (
    phase_trim_on_neg == chan_a_phase_trim[3]) else $error("phase side");
  a_phase_steps: assert property (
    !chan_a_phase_trim[3] |-> phase_trim_steps == chan_a_phase_trim[2:0])
    else $error("phase steps wrong");
  a_phase_neg_steps: assert property (
    chan_a_phase_trim[3] |-> phase_trim_steps ==
    ((chan_a_phase_trim == 4'hf) ? 3'h7 : chan_a_phase_trim[2:0] + 3'h1))
    else $error("negative phase steps wrong");
  a_idle_stable: assert property (
    csb && $past(csb) && $past(csb, 2) |-> $stable(sample_clock_divide) &&
    $stable(chan_a_phase_trim) && $stable(sample_format_select))
    else $error("setting moved outside a frame");
  a_idle_quiet: assert property (
    csb |-> !sdo_oe) else $error("sdo driven while deselected");
  // Main scenarios reached.
  c_bias_high: cover property (sysref_bias_high);
  c_amp_reserved: cover property (amp_trim_reserved);
  c_read_data: cover property (sdo_oe);
  c_divide_eight: cover property (clock_divide_ratio == 4'h8);
endmodule
bind adc_mode_and_trim_regs adc_mode_trim_checker chk (
  .clk(clk), .rst_b(rst_b), .csb(csb), .sdo_oe(sdo_oe),
  .sysref_in(sysref_in), .sample_format_select(sample_format_select),
  .sysref_bias_low(sysref_bias_low), .sysref_bias_high(sysref_bias_high),
  .sysref_gate_enable(sysref_gate_enable), .sysref_gated(sysref_gated),
  .sample_clock_divide(sample_clock_divide),
  .clock_divide_ratio(clock_divide_ratio),
  .chan_a_amplitude_trim(chan_a_amplitude_trim),
  .chan_a_phase_trim(chan_a_phase_trim), .amp_trim_steps(amp_trim_steps),
  .amp_trim_pos_up(amp_trim_pos_up), .amp_trim_reserved(amp_trim_reserved),
  .phase_trim_steps(phase_trim_steps), .phase_trim_on_neg(phase_trim_on_neg)
);
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Register-level tests of the mode and trim bank.
// Assumes: 250 MHz clock, host model on the serial control port.
// Notes:   Expected values come from field layouts and reset values.
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_trim_defs.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        up = 1'b1;
  logic        sref = 1'b0;
  logic [31:0] q;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  wire         csb, sclk, sdi, sdo, sdo_oe, fmt, b_lo, b_hi, gate, gated;
  wire         pos_up, amp_res, ph_neg;
  wire [1:0]   div, amp_st;
  wire [3:0]   ratio, ph;
  wire [2:0]   amp, ph_st;
  adc_mode_and_trim_regs uut (.clk(clk), .rst_b(rst_b), .csb(csb),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .stream_address_up(up), .sysref_in(sref), .sample_format_select(fmt),
    .sysref_bias_low(b_lo), .sysref_bias_high(b_hi),
    .sysref_gate_enable(gate), .sysref_gated(gated),
    .sample_clock_divide(div), .clock_divide_ratio(ratio),
    .chan_a_amplitude_trim(amp), .chan_a_phase_trim(ph),
    .amp_trim_steps(amp_st), .amp_trim_pos_up(pos_up),
    .amp_trim_reserved(amp_res), .phase_trim_steps(ph_st),
    .phase_trim_on_neg(ph_neg));
  spi_host_model host (.clk(clk), .csb(csb), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));
  // Clock, a toggling SYSREF level and the hang limit.
  always #2 clk = ~clk;
  always @(posedge clk) sref <= ~sref;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      complete_run();
    end
  end
  // Compare one value and count it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Single-byte register write.
  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    host.frame(1'b0, a, 1, {v, 24'h0}, 4, q);
  endtask
  // Print the counts and the verdict, then stop.
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Test sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    host.frame(1'b1, `OFS_OUTPUT_FORMAT_SYSREF, 3, 32'h0, 7, q);
    check(q, 32'h818000);
    check(fmt, 1'b1);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_OUTPUT_FORMAT_SYSREF, {3'h0, i[1:0], 3'h5});
      check({fmt, b_lo, b_hi}, {1'b0, i == 1, i == 2});
      @(negedge clk) check(gated, sref);
      @(negedge clk) check(gated, sref);
      wr(`OFS_SAMPLE_CLOCK_DIVIDE, {3'h4, i[1:0], 3'h0});
      check(ratio, 4'h1 << i);
      check(div, i);
    end
    $display("test format_divide done");
    for (int i = 0; i < 16; i++) begin
      wr(`OFS_CHAN_A_BALANCE_TRIM, {1'b0, i[2:0], i[3:0]});
      check({amp, ph}, {i[2:0], i[3:0]});
      check({amp_res, pos_up, amp_st}, {i[2:0] == 4, i[2:0] > 4, i[1:0]});
      check(ph_neg, i[3]);
      if (i < 8) check(ph_st, i);
      else check(ph_st, (i == 15) ? 7 : i - 7);
    end
    $display("test trim_codes done");
    host.frame(1'b0, `OFS_OUTPUT_FORMAT_SYSREF, 2, 32'h8188_0000, 4, q);
    check({fmt, gate, gated, div}, 5'h11);
    @(negedge clk) check(gated, 1'b0);
    @(negedge clk) check(gated, 1'b0);
    wr(15'h0011, 8'hff);
    up <= 1'b0;
    host.frame(1'b1, `OFS_CHAN_A_BALANCE_TRIM, 4, 32'h0, 4, q);
    check(q, 32'h7f88_8100);
    $display("test stream_down done");
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    up <= 1'b1;
    host.frame(1'b1, `OFS_OUTPUT_FORMAT_SYSREF, 3, 32'h0, 4, q);
    check(q, 32'h818000);
    check({fmt, gate, div, amp, ph}, 11'h400);
    $display("test mid_reset done");
    complete_run();
  end
endmodule
`default_nettype wire
